// file: rtl/motor_protect.sv
// Servo drive protection and current-loop parameter holding logic
`timescale 1ns/1ps
`include "motor_protect_consts.svh"
module motor_protect
  import motor_protect_pkg::*;
#(
  parameter int CUR_W = `CUR_W,
  parameter int TMR_W = `TMR_W
) (
  input  wire logic                MCLK_I,
  input  wire logic                RST_I,
  input  wire logic                ENABLE_I,
  input  wire logic                DRIVE_RESET_I,
  input  wire logic                PARAM_WR_I,
  input  wire logic [15:0]         BW_HZ_I,
  input  wire logic [6:0]          KP_PCT_I,
  input  wire logic [6:0]          KI_PCT_I,
  input  wire logic [6:0]          MASTER_PCT_I,
  input  wire drive_mode_t         MODE_I,
  input  wire logic [CUR_W-1:0]    CUR_LIMIT_I,
  input  wire logic [CUR_W-1:0]    CUR_MAX_I,
  input  wire logic [CUR_W-1:0]    OVERSPEED_I,
  input  wire logic [CUR_W-1:0]    FOLLOW_LIMIT_I,
  input  wire logic [CUR_W-1:0]    LS_TRIP_CUR_I,
  input  wire logic [TMR_W-1:0]    LS_TRIP_TIME_I,
  input  wire logic                FOLD_EN_I,
  input  wire logic [CUR_W-1:0]    FOLD_TRIP_CUR_I,
  input  wire logic [7:0]          FOLD_RATE_I,
  input  wire logic [CUR_W-1:0]    MOT_ALLOW_CUR_I,
  input  wire logic [CUR_W-1:0]    DRV_ALLOW_CUR_I,
  input  wire logic [TMR_W-1:0]    MOT_ALLOW_TIME_I,
  input  wire logic [TMR_W-1:0]    DRV_ALLOW_TIME_I,
  input  wire logic [CUR_W-1:0]    CUR_CMD_I,
  input  wire logic [CUR_W-1:0]    CUR_MEAS_I,
  input  wire logic [CUR_W-1:0]    VEL_MEAS_I,
  input  wire logic [CUR_W-1:0]    FOLLOW_ERR_I,
  output logic                     PARAM_REJ_O,
  output logic [15:0]              BW_HZ_O,
  output logic [13:0]              KP_EFF_O,
  output logic [13:0]              KI_EFF_O,
  output logic [CUR_W-1:0]         CUR_OUT_O,
  output logic [CUR_W-1:0]         CUR_LIM_EFF_O,
  output logic                     DRIVE_ON_O,
  output logic                     OVERSPEED_O,
  output logic                     FOLLOW_FAULT_O,
  output logic                     LS_FAULT_O,
  output logic                     FOLD_ACTIVE_O,
  output logic [CUR_W-1:0]         TE_CUR_O,
  output logic [TMR_W-1:0]         TE_TIME_O
);
  // Widths outside this span break the packed state and the comparators
  if (CUR_W < 8 || CUR_W > 32 || TMR_W < 4 || TMR_W > 32) begin : width_check
    $error("motor_protect: unsupported width");
  end

  typedef struct packed {
    logic [15:0]      bw;
    logic [6:0]       kp;
    logic [6:0]       ki;
    logic [6:0]       mg;
    logic             rej;
    logic [13:0]      kp_eff;
    logic [13:0]      ki_eff;
    logic [CUR_W-1:0] cur_out;
    logic [CUR_W-1:0] lim_eff;
    logic             drive_on;
    logic             ovs;
    logic             ffault;
    logic             lsfault;
    logic             fold;
    logic [TMR_W-1:0] ls_tmr;
    logic [7:0]       fold_cnt;
    logic [CUR_W-1:0] te_cur;
    logic [TMR_W-1:0] te_time;
    logic [1:0]       en_s;
    logic [1:0]       rst_s;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Fold back usable only when checked and below the configured limit
  function automatic logic fold_ok(input logic en, input logic [CUR_W-1:0] trip,
                                   input logic [CUR_W-1:0] lim);
    fold_ok = en && (trip < lim);
  endfunction

  function automatic logic [CUR_W-1:0] min_cur(input logic [CUR_W-1:0] a,
                                               input logic [CUR_W-1:0] b);
    min_cur = (a < b) ? a : b;
  endfunction

  logic [CUR_W-1:0] lim_cfg;
  logic             fold_on;
  logic [CUR_W:0]   ramp;

  always_comb begin
    s_d = s_q;
    s_d.en_s  = {s_q.en_s[0], ENABLE_I};
    s_d.rst_s = {s_q.rst_s[0], DRIVE_RESET_I};
    // Parameters only while disabled; out-of-range values refused whole
    s_d.rej = 1'b0;
    if (PARAM_WR_I) begin
      if (s_q.drive_on || BW_HZ_I < `BW_MIN_HZ || BW_HZ_I > `BW_MAX_HZ ||
          KP_PCT_I > `GAIN_MAX_PCT || KI_PCT_I > `GAIN_MAX_PCT ||
          MASTER_PCT_I > `GAIN_MAX_PCT) begin
        s_d.rej = 1'b1;
      end else begin
        s_d.bw = BW_HZ_I;
        s_d.kp = KP_PCT_I;
        s_d.ki = KI_PCT_I;
        s_d.mg = MASTER_PCT_I;
      end
    end
    s_d.kp_eff = 14'(s_q.kp * s_q.mg);
    s_d.ki_eff = 14'(s_q.ki * s_q.mg);

    lim_cfg = min_cur(CUR_LIMIT_I, CUR_MAX_I);
    fold_on = fold_ok(FOLD_EN_I, FOLD_TRIP_CUR_I, lim_cfg);
    ramp = '0;
    s_d.fold = fold_on && (CUR_MEAS_I > FOLD_TRIP_CUR_I);
    s_d.fold_cnt = s_q.fold_cnt + 8'h01;
    if (!s_d.fold) begin
      s_d.lim_eff = lim_cfg;
      s_d.fold_cnt = 8'h00;
    end else begin
      if (s_q.lim_eff > lim_cfg) begin
        s_d.lim_eff = lim_cfg;
      end else if (s_q.fold_cnt >= FOLD_RATE_I) begin
        s_d.fold_cnt = 8'h00;
        ramp = {1'b0, s_q.lim_eff} - {{CUR_W{1'b0}}, 1'b1};
        s_d.lim_eff = (s_q.lim_eff > FOLD_TRIP_CUR_I) ? ramp[CUR_W-1:0]
                                                       : FOLD_TRIP_CUR_I;
      end
    end

    // Low-speed breaker: up by one, down by two, floor at zero
    if (CUR_MEAS_I > LS_TRIP_CUR_I) begin
      if (s_q.ls_tmr != {TMR_W{1'b1}}) s_d.ls_tmr = s_q.ls_tmr + 1'b1;
    end else if (CUR_MEAS_I < LS_TRIP_CUR_I) begin
      s_d.ls_tmr = (s_q.ls_tmr > TMR_W'(2)) ? s_q.ls_tmr - TMR_W'(2)
                                            : '0;
    end
    // Drive reset clears; a fault arising in the same cycle wins
    if (s_q.rst_s[1]) begin
      s_d.lsfault = 1'b0;
      s_d.ffault  = 1'b0;
      s_d.ls_tmr  = '0;
    end
    if (s_q.ls_tmr > LS_TRIP_TIME_I) s_d.lsfault = 1'b1;
    if (MODE_I == MODE_POSITION && FOLLOW_ERR_I > FOLLOW_LIMIT_I) s_d.ffault = 1'b1;
    s_d.ovs = VEL_MEAS_I > OVERSPEED_I;
    s_d.drive_on = s_q.en_s[1] && !s_d.lsfault && !s_d.ffault && !s_d.ovs;
    // New limit, so a lowered limit never lets one cycle of excess through
    s_d.cur_out = !s_q.drive_on ? '0 : min_cur(CUR_CMD_I, s_d.lim_eff);

    // Prediction figures from zero start; motor and drive figures supplied
    s_d.te_cur  = min_cur(MOT_ALLOW_CUR_I, DRV_ALLOW_CUR_I);
    s_d.te_time = (MOT_ALLOW_TIME_I < DRV_ALLOW_TIME_I) ? MOT_ALLOW_TIME_I
                                                        : DRV_ALLOW_TIME_I;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q <= '0;
      s_q.bw <= `BW_RESET_HZ;
      s_q.kp <= `GAIN_RESET_PCT;
      s_q.ki <= `GAIN_RESET_PCT;
      s_q.mg <= `MASTER_RESET_PCT;
    end else begin
      s_q <= s_d;
    end
  end

  assign PARAM_REJ_O    = s_q.rej;
  assign BW_HZ_O        = s_q.bw;
  assign KP_EFF_O       = s_q.kp_eff;
  assign KI_EFF_O       = s_q.ki_eff;
  assign CUR_OUT_O      = s_q.cur_out;
  assign CUR_LIM_EFF_O  = s_q.lim_eff;
  assign DRIVE_ON_O     = s_q.drive_on;
  assign OVERSPEED_O    = s_q.ovs;
  assign FOLLOW_FAULT_O = s_q.ffault;
  assign LS_FAULT_O     = s_q.lsfault;
  assign FOLD_ACTIVE_O  = s_q.fold;
  assign TE_CUR_O       = s_q.te_cur;
  assign TE_TIME_O      = s_q.te_time;

  param_lock_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    PARAM_WR_I && s_q.drive_on |=> s_q.rej && $stable(s_q.bw))
    else $error("parameter taken while enabled");
  bw_range_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_q.bw >= `BW_MIN_HZ && s_q.bw <= `BW_MAX_HZ)
    else $error("bandwidth out of range");
  gain_range_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_q.kp <= `GAIN_MAX_PCT && s_q.ki <= `GAIN_MAX_PCT)
    else $error("gain above hundred percent");
  master_scale_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !$past(RST_I) |-> s_q.kp_eff == 14'($past(s_q.kp) * $past(s_q.mg)))
    else $error("master gain not applied");
  cur_clamp_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_q.cur_out <= s_q.lim_eff && s_q.cur_out <= $past(CUR_MAX_I) || $rose(s_q.drive_on))
    else $error("output current over limit");
  overspeed_off_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    VEL_MEAS_I > OVERSPEED_I |=> !s_q.drive_on ##1 s_q.cur_out == '0)
    else $error("drive on while overspeed");
  follow_mode_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $rose(s_q.ffault) |-> $past(MODE_I) == MODE_POSITION)
    else $error("following fault outside position mode");
  ls_up_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    CUR_MEAS_I > LS_TRIP_CUR_I && !s_q.rst_s[1] && s_q.ls_tmr != {TMR_W{1'b1}}
    |=> s_q.ls_tmr == $past(s_q.ls_tmr) + 1'b1)
    else $error("breaker timer did not advance");
  ls_down_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    CUR_MEAS_I < LS_TRIP_CUR_I && !s_q.rst_s[1] && s_q.ls_tmr > TMR_W'(2)
    |=> s_q.ls_tmr == $past(s_q.ls_tmr) - TMR_W'(2))
    else $error("breaker timer not reduced by two");
  ls_latch_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_q.lsfault && !s_q.rst_s[1] |=> s_q.lsfault)
    else $error("low-speed fault dropped without reset");
  fold_off_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !FOLD_EN_I |=> !s_q.fold)
    else $error("fold back active while disabled");
  fold_recover_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !s_q.fold |-> s_q.lim_eff == $past(min_cur(CUR_LIMIT_I, CUR_MAX_I)) || $past(RST_I))
    else $error("fold back limit did not recover");
  te_min_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ##1 s_q.te_cur <= $past(MOT_ALLOW_CUR_I) && s_q.te_cur <= $past(DRV_ALLOW_CUR_I))
    else $error("thermal limit not the smaller");
  ls_floor_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    s_q.ls_tmr <= TMR_W'(2) && CUR_MEAS_I < LS_TRIP_CUR_I |=> s_q.ls_tmr == '0)
    else $error("breaker timer wrapped");

  fold_seen_c:  cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(s_q.fold));
  ls_trip_c:    cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(s_q.lsfault));
  follow_c:     cover property (@(posedge MCLK_I) disable iff (RST_I) $rose(s_q.ffault));
  param_ok_c:   cover property (@(posedge MCLK_I) disable iff (RST_I)
    PARAM_WR_I && !s_q.drive_on ##1 !s_q.rej);
endmodule

// file: rtl/motor_protect_consts.svh
// Constants for the servo protection and current-loop parameter block
`ifndef MOTOR_PROTECT_CONSTS_SVH
`define MOTOR_PROTECT_CONSTS_SVH
`define BW_MIN_HZ        16'd1
`define BW_MAX_HZ        16'd4000
`define BW_RESET_HZ      16'd2000
`define GAIN_MAX_PCT     7'd100
`define GAIN_RESET_PCT   7'd50
`define MASTER_RESET_PCT 7'd100
`define CUR_W            16
`define TMR_W            24
`define FOLD_RATE_W      8
`endif

// file: rtl/motor_protect_pkg.sv
// Types for the servo protection block
package motor_protect_pkg;
  typedef enum logic [1:0] {
    MODE_CURRENT  = 2'b00,
    MODE_VELOCITY = 2'b01,
    MODE_POSITION = 2'b10
  } drive_mode_t;
endpackage

// file: sim/feedback_model.sv
// Far-side model: motor current, speed and following error slewing to targets
`timescale 1ns/1ps
module feedback_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] cur_tgt_i,
  input  wire logic [15:0] vel_tgt_i,
  input  wire logic [15:0] err_tgt_i,
  input  wire logic [15:0] step_i,
  output logic      [15:0] cur_o,
  output logic      [15:0] vel_o,
  output logic      [15:0] err_o
);
  // Step 0 answers at once; a nonzero step ramps like a real winding
  function automatic logic [15:0] slew(input logic [15:0] v, t, s);
    if (s == 16'h0 || (v > t ? v - t : t - v) <= s) return t;
    return v > t ? v - s : v + s;
  endfunction
  initial {cur_o, vel_o, err_o} = '0;
  always @(posedge clk_i) begin
    cur_o <= slew(cur_o, cur_tgt_i, step_i);
    vel_o <= slew(vel_o, vel_tgt_i, step_i);
    err_o <= slew(err_o, err_tgt_i, step_i);
  end
endmodule

// file: sim/motor_protect_bench.sv
// Self-checking bench for the servo protection block
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c,n) begin k=0; while ((c)!==1'b1 && k<n) begin @(negedge MCLK_I); k++; end \
  if ((c)!==1'b1) begin miscompares++; wrap_up; end end
module motor_protect_bench;
  import motor_protect_pkg::*;
  logic        MCLK_I, RST_I, en, drst, pwr, fen, r, rej, on, ospo, ffl, lsf, fa;
  logic [15:0] bw, lim, cmax, ospd, flim, lstc, ftc, mac, dac, cmd, ct, vt, et, st;
  logic [15:0] cm, vm, fe, bwo, cout, leff, tec;
  logic [23:0] lstt, mat, dat, tet;
  logic [13:0] kpe, kie;
  logic [7:0]  frate;
  logic [6:0]  kp, ki, mp;
  drive_mode_t mode;
  int          miscompares, tests_run, k;
  motor_protect dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .ENABLE_I(en), .DRIVE_RESET_I(drst),
    .PARAM_WR_I(pwr), .BW_HZ_I(bw), .KP_PCT_I(kp), .KI_PCT_I(ki), .MASTER_PCT_I(mp),
    .MODE_I(mode), .CUR_LIMIT_I(lim), .CUR_MAX_I(cmax), .OVERSPEED_I(ospd),
    .FOLLOW_LIMIT_I(flim), .LS_TRIP_CUR_I(lstc), .LS_TRIP_TIME_I(lstt), .FOLD_EN_I(fen),
    .FOLD_TRIP_CUR_I(ftc), .FOLD_RATE_I(frate), .MOT_ALLOW_CUR_I(mac),
    .DRV_ALLOW_CUR_I(dac), .MOT_ALLOW_TIME_I(mat), .DRV_ALLOW_TIME_I(dat),
    .CUR_CMD_I(cmd), .CUR_MEAS_I(cm), .VEL_MEAS_I(vm), .FOLLOW_ERR_I(fe),
    .PARAM_REJ_O(rej), .BW_HZ_O(bwo), .KP_EFF_O(kpe), .KI_EFF_O(kie), .CUR_OUT_O(cout),
    .CUR_LIM_EFF_O(leff), .DRIVE_ON_O(on), .OVERSPEED_O(ospo), .FOLLOW_FAULT_O(ffl),
    .LS_FAULT_O(lsf), .FOLD_ACTIVE_O(fa), .TE_CUR_O(tec), .TE_TIME_O(tet));
  feedback_model fb (.clk_i(MCLK_I), .cur_tgt_i(ct), .vel_tgt_i(vt), .err_tgt_i(et),
    .step_i(st), .cur_o(cm), .vel_o(vm), .err_o(fe));
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge MCLK_I);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [15:0] b, input logic [6:0] p, i, m);
    cyc(1);
    {pwr, bw, kp, ki, mp} <= {1'b1, b, p, i, m};
    cyc(1);
    pwr <= 1'b0;
    r = 1'b0;
    repeat (3) begin
      @(negedge MCLK_I);
      r = r | rej;
    end
  endtask
  // Drive reset needs its synchroniser, so hold it several cycles
  task automatic restart;
    cyc(1);
    {en, drst} <= 2'b01;
    cyc(6);
    {en, drst} <= 2'b10;
    `WAIT(on, 10)
  endtask
  task automatic t_params;
    `CHK(bwo, 16'h07d0)
    `CHK(kpe, 14'h1388)
    wr(16'h0fa0, 7'h64, 7'h00, 7'h28);
    `CHK(r, 1'b0)
    `CHK(bwo, 16'h0fa0)
    `CHK(kpe, 14'h0fa0)
    `CHK(kie, 14'h0000)
    wr(16'h0fa1, 7'h10, 7'h10, 7'h10);
    `CHK(r, 1'b1)
    wr(16'h0000, 7'h10, 7'h10, 7'h10);
    `CHK(r, 1'b1)
    wr(16'h0001, 7'h00, 7'h65, 7'h64);
    `CHK(r, 1'b1)
    `CHK(bwo, 16'h0fa0)
    wr(16'h0001, 7'h00, 7'h64, 7'h64);
    `CHK(kie, 14'h2710)
    cyc(1);
    {mac, dac, mat, dat} <= {16'h0050, 16'h0040, 24'h001000, 24'h002000};
    nx(4);
    `CHK(tec, 16'h0040)
    `CHK(tet, 24'h001000)
    $display("parameter test done");
  endtask
  task automatic t_enable;
    cyc(1);
    en <= 1'b1;
    `WAIT(on, 10)
    wr(16'h07d0, 7'h32, 7'h32, 7'h64);
    `CHK(r, 1'b1)
    `CHK(bwo, 16'h0001)
    cyc(1);
    {cmax, cmd} <= {16'h0180, 16'h0300};
    nx(4);
    `CHK(cout, 16'h0180)
    cyc(1);
    cmax <= 16'h0400;
    nx(4);
    `CHK(cout, 16'h0200)
    cyc(1);
    mode <= MODE_VELOCITY;
    et <= 16'h0080;
    nx(6);
    `CHK(ffl, 1'b0)
    cyc(1);
    et <= 16'h0040;
    cyc(2);
    mode <= MODE_POSITION;
    nx(6);
    `CHK(ffl, 1'b0)
    cyc(1);
    et <= 16'h0041;
    `WAIT(ffl, 6)
    cyc(1);
    et <= 16'h0000;
    restart;
    `CHK(ffl, 1'b0)
    $display("enable test done");
  endtask
  task automatic t_breaker;
    cyc(1);
    ct <= 16'h0200;
    cyc(8);
    ct <= 16'h0080;
    cyc(4);
    ct <= 16'h0200;
    cyc(8);
    ct <= 16'h0080;
    nx(6);
    `CHK(lsf, 1'b0)
    cyc(1);
    ct <= 16'h0200;
    `WAIT(lsf, 20)
    `CHK(k >= 10, 1'b1)
    cyc(1);
    ct <= 16'h0080;
    nx(30);
    `CHK(lsf, 1'b1)
    restart;
    `CHK(lsf, 1'b0)
    $display("breaker test done");
  endtask
  task automatic t_fold;
    cyc(1);
    {fen, lstt, ct} <= {1'b1, 24'hffffff, 16'h0180};
    `WAIT(fa, 6)
    nx(20);
    `CHK(leff < 16'h0200 && leff > 16'h0100, 1'b1)
    nx(300);
    `CHK(leff, 16'h0100)
    cyc(1);
    ct <= 16'h0080;
    nx(3);
    `CHK(fa, 1'b0)
    `CHK(leff, 16'h0200)
    cyc(1);
    {ftc, ct} <= {16'h0200, 16'h0300};
    nx(4);
    `CHK(fa, 1'b0)
    cyc(1);
    {fen, ftc} <= {1'b0, 16'h0100};
    nx(4);
    `CHK(fa, 1'b0)
    $display("fold back test done");
  endtask
  task automatic t_speed;
    cyc(1);
    {ct, st, vt} <= {16'h0000, 16'h0100, 16'h1800};
    `WAIT(ospo, 40)
    `CHK(vm > 16'h1000, 1'b1)
    nx(2);
    `CHK(on, 1'b0)
    nx(1);
    `CHK(cout, 16'h0000)
    cyc(1);
    vt <= 16'h0000;
    nx(30);
    restart;
    `CHK(ospo, 1'b0)
    $display("overspeed test done");
  endtask
  initial begin
    MCLK_I = 1'b0;
    forever #50 MCLK_I = ~MCLK_I;
  end
  initial begin
    {RST_I, en, drst, pwr, fen, frate, mode} = {1'b1, 4'h0, 8'h00, MODE_POSITION};
    {bw, kp, ki, mp, cmd, ct, vt, et, st} = {16'h07d0, 21'h0, 80'h0};
    {lim, cmax, ospd, flim, lstc, ftc} = {16'h0200, 16'h0400, 16'h1000, 16'h0040,
      16'h0100, 16'h0100};
    {lstt, mac, dac, mat, dat} = {24'h00000a, 16'h0010, 16'h0020, 24'h0100, 24'h0200};
    cyc(2);
    RST_I <= 1'b0;
    nx(3);
    t_params;
    t_enable;
    t_breaker;
    t_fold;
    t_speed;
    wrap_up;
  end
endmodule
